// file: hw/scpm_cfg.svh
// constants of the system clock and power mode control block
// assumes a 20 MHz bus clock and word addressing on the register bus
`ifndef SCPM_CFG_SVH
`define SCPM_CFG_SVH

// register word indices on the bus
`define SCPM_OFS_SYS_CLK_CTRL 3'h0
`define SCPM_OFS_FAST_OSC_CTRL 3'h1
`define SCPM_OFS_IRQ_STATUS 3'h2
`define SCPM_OFS_IRQ_CLEAR 3'h3
`define SCPM_OFS_IRQ_ENABLE 3'h4
`define SCPM_OFS_POWER_STATUS 3'h5

// field positions
`define SCPM_SEL_MSB 7
`define SCPM_SEL_LSB 5
`define SCPM_FAST_IDLE_BIT 1
`define SCPM_SLOW_IDLE_BIT 0
`define SCPM_FOSC_STABLE_BIT 1
`define SCPM_FOSC_ENABLE_BIT 0
`define SCPM_PS_PDF_BIT 0
`define SCPM_PS_TO_BIT 1
`define SCPM_PS_MODE_LSB 2
`define SCPM_PS_BUSY_BIT 7

// interrupt event bits
`define SCPM_EV_FAST_STABLE 0
`define SCPM_EV_SWITCH_DONE 1
`define SCPM_EV_HALT 2
`define SCPM_EV_WAKE 3
`define SCPM_EV_WIDTH 4

// reset values
`define SCPM_SCC_RESET 8'h00
`define SCPM_FOSC_EN_RESET 1'b1
`define SCPM_SEL_SLOW 3'h7

// timing
`define SCPM_CLK_HZ 20000000
`define SCPM_FAST_HZ 4000000
`define SCPM_SLOW_HZ 32000
`define SCPM_FAST_PERIOD_CYC (`SCPM_CLK_HZ / `SCPM_FAST_HZ)
`define SCPM_SLOW_PERIOD_CYC (`SCPM_CLK_HZ / `SCPM_SLOW_HZ)
`define SCPM_SETTLE_NS 16000
`define SCPM_SETTLE_CYC ((`SCPM_SETTLE_NS * (`SCPM_CLK_HZ / 1000000) + 999) / 1000)
`define SCPM_SWITCH_CUR_PERIODS 4

`endif

// file: hw/scpm_clk_switch.sv
// glitch-free selector of the system clock among eight clock levels
// assumes all levels are flop outputs of the bus clock domain
`include "scpm_cfg.svh"
module scpm_clk_switch (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// candidates
	input wire logic [7:0] levels,
	input wire logic [7:0] ready,
	// control
	input wire scpm_pkg::scpm_sel_type target,
	input wire logic gate,
	// outputs
	output scpm_pkg::scpm_sel_type current,
	output logic sys_clk,
	output logic busy,
	output logic done
);
	import scpm_pkg::*;
	logic [2:0] edges_reg; // rising edges of the old clock seen
	logic prev_reg; // old clock level one cycle ago
	logic gate_reg; // gate, moved only while the clock is low
	wire logic cur_level = levels[current];
	wire logic cur_rise = cur_level & ~prev_reg;
	wire logic want = (target != current);
	wire logic waited = (edges_reg == 3'(`SCPM_SWITCH_CUR_PERIODS));
	// hand over only with both clocks low, so no runt pulse appears
	wire logic take = want & waited & ready[target] & ~cur_level &
		~levels[target];

	// --------------------------------------------------------------
	// switch sequence
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			current <= '0;
			edges_reg <= '0;
			prev_reg <= 1'b0;
			gate_reg <= 1'b0;
			sys_clk <= 1'b0;
			done <= 1'b0;
		end else begin
			prev_reg <= cur_level;
			done <= take;
			if (take) begin
				current <= target;
				edges_reg <= '0;
			end else if (want && cur_rise && !waited) begin
				edges_reg <= edges_reg + 3'(1);
			end else if (!want) begin
				edges_reg <= '0;
			end
			if (!cur_level)
				gate_reg <= gate;
			sys_clk <= cur_level & gate_reg & ~take;
		end
	end
	assign busy = want;
endmodule

// file: hw/scpm_osc_gen.sv
// model of one on-chip rc oscillator as a clock-rate level
// assumes the bus clock is several times faster than the oscillator
`include "scpm_cfg.svh"
module scpm_osc_gen #(
	parameter int PERIOD = 5,
	parameter int SETTLE = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// control
	input wire logic run,
	// outputs
	output logic level,
	output logic stable
);
	localparam int CW = $clog2(PERIOD + 1);
	localparam int SW = $clog2(SETTLE + 1);
	logic [CW-1:0] cnt_reg; // phase counter
	logic [SW-1:0] settle_reg; // settling counter
	wire logic cnt_wrap = (cnt_reg == CW'(PERIOD - 1));
	wire logic settled = (settle_reg == SW'(SETTLE));

	// --------------------------------------------------------------
	// phase and settling, both restart whenever the oscillator stops
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_reg <= '0;
			settle_reg <= '0;
			level <= 1'b0;
			stable <= 1'b0;
		end else if (!run) begin
			cnt_reg <= '0;
			settle_reg <= '0;
			level <= 1'b0;
			stable <= 1'b0;
		end else begin
			cnt_reg <= cnt_wrap ? '0 : cnt_reg + CW'(1);
			settle_reg <= settled ? settle_reg : settle_reg + SW'(1);
			level <= (cnt_reg < CW'(PERIOD / 2));
			stable <= settled;
		end
	end
endmodule

// file: hw/scpm_pkg.sv
// types shared by the clock and power mode control files
// assumes scpm_cfg.svh for the numeric constants
package scpm_pkg;
	// operating mode, one-hot
	typedef enum logic [4:0] {
		scpm_run = 5'b00001,
		scpm_sleep = 5'b00010,
		scpm_idle_slow_only = 5'b00100,
		scpm_idle_both_clocks = 5'b01000,
		scpm_idle_fast_only = 5'b10000
	} scpm_mode_type;
	// system clock select code
	typedef logic [2:0] scpm_sel_type;
endpackage

// file: hw/scpm_top.sv
// system clock selection and low-power mode control
// assumes the core's halt and wake strobes, watchdog strobes and the
// avalon-mm master all run on clk; oscillators are modelled as levels
//
// Local design decisions: the address map and the Avalon-MM slave port.
`include "scpm_cfg.svh"

// Summary of operation
// - select code picks fast divided or slow clock
// - fast clock comes from 4MHz rc oscillator
// - slow clock comes from 32kHz rc oscillator
// - slow oscillator also feeds watchdog and time base
// - fast mode runs every clock and oscillator
// - slow mode: fast clock follows enable bit
// - halt with both enables low enters sleep
// - halt with slow enable only enters idle_slow_only
// - halt with both enables high enters idle_both_clocks
// - halt with fast enable only enters idle_fast_only
// - bit 1 keeps fast oscillator during halt
// - bit 0 keeps slow peripheral clock during halt
// - enabling fast oscillator clears, then sets stable
// - fast oscillator enable, power-on value one
// - clock switch completes within documented delay
// - unimplemented control bits read as zero
// - halt sets power-down flag, clears timeout flag
module scpm_top (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// avalon-mm slave
	input wire logic [2:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// cpu core strobes
	input wire logic cpu_halt,
	input wire logic wake_request,
	// watchdog side
	input wire logic wdt_enable,
	input wire logic wdt_timeout,
	input wire logic wdt_clear,
	// clocks out
	output logic sys_clk,
	output logic fast_clk,
	output logic slow_clk,
	output logic wdt_clk,
	output logic timebase_clk,
	// status out
	output logic cpu_run,
	output scpm_pkg::scpm_mode_type mode,
	output logic power_down_flag,
	output logic watchdog_timeout_flag,
	output logic irq
);
	import scpm_pkg::*;

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	// control registers
	scpm_sel_type sys_clk_select_reg; // requested clock code
	logic fast_idle_enable_reg; // fast oscillator kept in halt
	logic slow_idle_enable_reg; // slow peripheral clock kept in halt
	logic fast_osc_enable_reg; // fast oscillator on in slow mode
	// interrupt registers
	logic [`SCPM_EV_WIDTH-1:0] irq_status_reg; // sticky events
	logic [`SCPM_EV_WIDTH-1:0] irq_enable_reg; // event mask
	// bus handshake
	logic ack_reg; // second cycle of an access
	logic [31:0] readdata_reg; // captured read data
	// power mode
	scpm_mode_type mode_reg; // current operating mode
	scpm_mode_type mode_next; // mode after this edge
	logic pdf_reg; // power-down flag
	logic to_reg; // watchdog timeout flag
	// oscillator model outputs
	logic fast_level; // fast rc oscillator level
	logic fast_stable; // fast oscillator settled
	logic slow_level; // slow rc oscillator level
	logic slow_stable; // slow oscillator settled
	logic fast_stable_prev_reg; // for the stable event
	// divider
	logic [5:0] div_reg; // counts fast rising edges
	logic fast_prev_reg; // fast level one cycle ago
	logic [7:0] cand_level; // level of each select code
	logic [7:0] cand_ready; // source of each code is stable
	// switch outputs
	scpm_sel_type cur_sel; // clock code in use
	logic switch_busy; // change of code still pending
	logic switch_done; // one-cycle pulse at the change
	// output clock registers
	logic fast_clk_reg;
	logic slow_clk_reg;
	logic wdt_clk_reg;
	localparam logic [7:0] SCC_RST = `SCPM_SCC_RESET; // reset image

	// --------------------------------------------------------------
	// bus decode
	// --------------------------------------------------------------
	wire logic access = read | write;
	wire logic wr_commit = write & ack_reg;
	wire logic lane0 = byteenable[0];
	wire logic hit_scc = (address == `SCPM_OFS_SYS_CLK_CTRL);
	wire logic hit_fosc = (address == `SCPM_OFS_FAST_OSC_CTRL);
	wire logic hit_stat = (address == `SCPM_OFS_IRQ_STATUS);
	wire logic hit_clr = (address == `SCPM_OFS_IRQ_CLEAR);
	wire logic hit_ien = (address == `SCPM_OFS_IRQ_ENABLE);
	wire logic hit_ps = (address == `SCPM_OFS_POWER_STATUS);
	wire logic wr_scc = wr_commit & hit_scc & lane0;
	wire logic wr_fosc = wr_commit & hit_fosc & lane0;
	wire logic wr_clr = wr_commit & hit_clr & lane0;
	wire logic wr_ien = wr_commit & hit_ien & lane0;
	wire logic [7:0] wbyte = writedata[7:0];

	// --------------------------------------------------------------
	// mode decode
	// --------------------------------------------------------------
	wire logic in_run = (mode_reg == scpm_run);
	wire logic in_sleep = (mode_reg == scpm_sleep);
	wire logic halt_take = cpu_halt & in_run;
	wire logic wake_take = wake_request & ~in_run;
	wire logic sel_slow = (sys_clk_select_reg == `SCPM_SEL_SLOW);
	wire logic cur_slow = (cur_sel == `SCPM_SEL_SLOW);
	// fast oscillator: in run forced on while any fast code is used or
	// pending, otherwise the enable bit; in halt the idle bit alone
	wire logic fast_on = in_run ?
		(fast_osc_enable_reg | ~sel_slow | ~cur_slow) :
		fast_idle_enable_reg;
	// low-speed oscillator: off only in sleep with watchdog off
	wire logic slow_rc_oscillator_on = ~in_sleep | wdt_enable;
	// slow peripheral clock follows the slow idle bit in halt
	wire logic fsub_on = in_run | slow_idle_enable_reg;
	// system clock in halt runs only if its source is kept
	wire logic sys_gate = in_run |
		(cur_slow ? slow_idle_enable_reg :
		fast_idle_enable_reg);
	wire logic fast_rise = fast_level & ~fast_prev_reg;
	wire logic fast_stable_rise = fast_stable & ~fast_stable_prev_reg;

	// --------------------------------------------------------------
	// read data selection
	// --------------------------------------------------------------
	wire logic [7:0] scc_read = {sys_clk_select_reg, 3'h0,
		fast_idle_enable_reg, slow_idle_enable_reg};
	wire logic [7:0] fosc_read = {6'h00, fast_stable,
		fast_osc_enable_reg};
	wire logic [7:0] ps_read = {switch_busy, mode_reg, to_reg,
		pdf_reg};
	wire logic [7:0] rd_byte =
		hit_scc ? scc_read :
		hit_fosc ? fosc_read :
		hit_stat ? {4'h0, irq_status_reg} :
		hit_ien ? {4'h0, irq_enable_reg} :
		hit_ps ? ps_read :
		8'h00; // clear register and unmapped words read zero

	// --------------------------------------------------------------
	// event vector for the interrupt block
	// --------------------------------------------------------------
	wire logic [`SCPM_EV_WIDTH-1:0] events = {wake_take, halt_take,
		switch_done, fast_stable_rise};
	wire logic [`SCPM_EV_WIDTH-1:0] clr_mask =
		wr_clr ? wbyte[`SCPM_EV_WIDTH-1:0] : '0;

	// --------------------------------------------------------------
	// oscillators
	// --------------------------------------------------------------
	// the fast model restarts its settle count whenever it is
	// switched on, so the stable flag drops first and rises later
	scpm_osc_gen #(
		.PERIOD(`SCPM_FAST_PERIOD_CYC),
		.SETTLE(`SCPM_SETTLE_CYC)
	) u_fast_osc (
		.clk(clk),
		.reset(reset),
		.run(fast_on),
		.level(fast_level),
		.stable(fast_stable)
	);

	// slow rc oscillator, settle kept short
	scpm_osc_gen #(
		.PERIOD(`SCPM_SLOW_PERIOD_CYC),
		.SETTLE(1)
	) u_slow_osc (
		.clk(clk),
		.reset(reset),
		.run(slow_rc_oscillator_on),
		.level(slow_level),
		.stable(slow_stable)
	);

	// --------------------------------------------------------------
	// divider: div_reg bit n-1 is the fast clock divided by 2^n
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_reg <= '0;
			fast_prev_reg <= 1'b0;
		end else begin
			fast_prev_reg <= fast_level;
			if (fast_rise)
				div_reg <= div_reg + 6'(1);
		end
	end

	// one candidate per select code
	assign cand_level[0] = fast_level;
	assign cand_ready[0] = fast_stable;
	genvar g;
	generate
		for (g = 1; g < 7; g++) begin : g_div
			// each divided stage toggles on the stage below
			assign cand_level[g] = div_reg[g-1];
			assign cand_ready[g] = fast_stable;
		end
	endgenerate
	assign cand_level[7] = slow_level;
	assign cand_ready[7] = slow_stable;

	// --------------------------------------------------------------
	// system clock selector
	// --------------------------------------------------------------
	// the change waits for a stable target, so leaving slow mode
	// with the fast oscillator off costs its full settling time
	scpm_clk_switch u_switch (
		.clk(clk),
		.reset(reset),
		.levels(cand_level),
		.ready(cand_ready),
		.target(sys_clk_select_reg),
		.gate(sys_gate),
		.current(cur_sel),
		.sys_clk(sys_clk),
		.busy(switch_busy),
		.done(switch_done)
	);

	// --------------------------------------------------------------
	// bus handshake: one wait state on every access
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ack_reg <= 1'b0;
			readdata_reg <= '0;
		end else begin
			ack_reg <= access & ~ack_reg;
			if (read && !ack_reg)
				readdata_reg <= {24'h000000, rd_byte};
		end
	end
	assign waitrequest = access & ~ack_reg;
	assign readdata = readdata_reg;

	// --------------------------------------------------------------
	// system clock control register
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sys_clk_select_reg <=
				SCC_RST[`SCPM_SEL_MSB:`SCPM_SEL_LSB];
			fast_idle_enable_reg <=
				SCC_RST[`SCPM_FAST_IDLE_BIT];
			slow_idle_enable_reg <=
				SCC_RST[`SCPM_SLOW_IDLE_BIT];
		end else if (wr_scc) begin
			sys_clk_select_reg <=
				wbyte[`SCPM_SEL_MSB:`SCPM_SEL_LSB];
			fast_idle_enable_reg <= wbyte[`SCPM_FAST_IDLE_BIT];
			slow_idle_enable_reg <= wbyte[`SCPM_SLOW_IDLE_BIT];
		end
	end

	// --------------------------------------------------------------
	// fast oscillator control: stable flag is read-only
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			fast_osc_enable_reg <= `SCPM_FOSC_EN_RESET;
		else if (wr_fosc)
			fast_osc_enable_reg <= wbyte[`SCPM_FOSC_ENABLE_BIT];
	end

	// --------------------------------------------------------------
	// power mode state machine
	// --------------------------------------------------------------
	always_comb begin
		mode_next = mode_reg;
		unique case (mode_reg)
			scpm_run: begin
				if (halt_take) begin
					unique case ({fast_idle_enable_reg,
						slow_idle_enable_reg})
						2'b00: mode_next = scpm_sleep;
						2'b01: mode_next = scpm_idle_slow_only;
						2'b11: mode_next = scpm_idle_both_clocks;
						2'b10: mode_next = scpm_idle_fast_only;
					endcase
				end
			end
			scpm_sleep, scpm_idle_slow_only, scpm_idle_both_clocks,
			scpm_idle_fast_only: begin
				// any wake source brings the core back
				if (wake_take)
					mode_next = scpm_run;
			end
			default: mode_next = scpm_run;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			mode_reg <= scpm_run;
		else
			mode_reg <= mode_next;
	end

	// --------------------------------------------------------------
	// status flags: a setting event wins over a clear
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pdf_reg <= 1'b0;
			to_reg <= 1'b0;
		end else begin
			if (halt_take)
				pdf_reg <= 1'b1;
			else if (wdt_clear)
				pdf_reg <= 1'b0;
			if (wdt_timeout)
				to_reg <= 1'b1;
			else if (halt_take || wdt_clear)
				to_reg <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// interrupt status and enable
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_status_reg <= '0;
			irq_enable_reg <= '0;
			fast_stable_prev_reg <= 1'b0;
		end else begin
			fast_stable_prev_reg <= fast_stable;
			// new events are kept even under a clear write
			irq_status_reg <= (irq_status_reg & ~clr_mask) | events;
			if (wr_ien)
				irq_enable_reg <= wbyte[`SCPM_EV_WIDTH-1:0];
		end
	end
	assign irq = |(irq_status_reg & irq_enable_reg);

	// --------------------------------------------------------------
	// peripheral clock outputs
	// --------------------------------------------------------------
	// gating these can shorten one high phase; unlike the system
	// clock no peripheral here counts on full-width pulses
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fast_clk_reg <= 1'b0;
			slow_clk_reg <= 1'b0;
			wdt_clk_reg <= 1'b0;
		end else begin
			fast_clk_reg <= fast_level;
			slow_clk_reg <= slow_level & fsub_on;
			wdt_clk_reg <= slow_level;
		end
	end
	assign fast_clk = fast_clk_reg;
	assign slow_clk = slow_clk_reg;
	assign wdt_clk = wdt_clk_reg;
	assign timebase_clk = slow_clk_reg;

	// --------------------------------------------------------------
	// status outputs
	// --------------------------------------------------------------
	assign cpu_run = in_run;
	assign mode = mode_reg;
	assign power_down_flag = pdf_reg;
	assign watchdog_timeout_flag = to_reg;
endmodule

// file: testbench/scpm_core_model.sv
// model of the cpu core strobes towards the block
// assumes the bench calls its tasks just after a rising edge
module scpm_core_model (
	// clock
	input wire logic clk,
	// strobes
	output logic cpu_halt,
	output logic wake_request
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle strobes from time zero
	initial begin
		cpu_halt = 1'b0;
		wake_request = 1'b0;
	end
	// one-cycle halt pulse; mode chosen by the idle enables
	task do_halt();
		@(posedge clk);
		cpu_halt <= 1'b1;
		@(posedge clk);
		cpu_halt <= 1'b0;
	endtask
	// one-cycle wake pulse
	task do_wake();
		@(posedge clk);
		wake_request <= 1'b1;
		@(posedge clk);
		wake_request <= 1'b0;
	endtask
endmodule

// file: testbench/scpm_top_props.sv
// checker of the clock and power mode control ports
// assumes it is bound to scpm_top and sees only its ports
module scpm_top_props (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register bus
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	input wire logic [31:0] readdata,
	// core and watchdog
	input wire logic cpu_halt,
	input wire logic wake_request,
	input wire logic wdt_enable,
	input wire logic wdt_timeout,
	// watched outputs
	input wire logic fast_clk,
	input wire logic slow_clk,
	input wire logic wdt_clk,
	input wire logic timebase_clk,
	input wire logic cpu_run,
	input wire scpm_pkg::scpm_mode_type mode,
	input wire logic power_down_flag,
	input wire logic watchdog_timeout_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	import scpm_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// clock outputs are flops, so allow a short lag after entry
	chk_halt_stops_core: assert property (
		cpu_halt && mode == scpm_run |=> !cpu_run && mode != scpm_run)
		else $error("halt did not stop the core");
	chk_wake_resumes: assert property (
		wake_request && mode != scpm_run |=> mode == scpm_run)
		else $error("wake did not resume run");
	chk_run_mode_agree: assert property (
		cpu_run == (mode == scpm_run))
		else $error("run output disagrees with mode");
	chk_halt_flags: assert property (
		cpu_halt && mode == scpm_run && !wdt_timeout
		|=> power_down_flag && !watchdog_timeout_flag)
		else $error("halt left flags wrong");
	chk_sleep_clocks: assert property (
		(mode == scpm_sleep) [*3] |-> !fast_clk && !slow_clk)
		else $error("clock runs in sleep");
	chk_sleep_lowspeed: assert property (
		(mode == scpm_sleep && !wdt_enable) [*3] |-> !wdt_clk)
		else $error("low-speed clock runs in sleep");
	chk_idle_slow_only: assert property (
		(mode == scpm_idle_slow_only) [*3] |-> !fast_clk)
		else $error("fast clock runs in slow idle");
	chk_idle_fast_only: assert property (
		(mode == scpm_idle_fast_only) [*3] |-> !slow_clk)
		else $error("slow clock runs in fast idle");
	chk_timebase_slow: assert property (
		cpu_run && $past(cpu_run) |-> timebase_clk == wdt_clk)
		else $error("time base and watchdog clocks differ in run");
	// a stop may cut a phase short, so bound high above, low below
	chk_fast_high: assert property (
		fast_clk [*2] |=> !fast_clk)
		else $error("fast clock high too long");
	chk_fast_low: assert property (
		$fell(fast_clk) |-> !fast_clk [*3])
		else $error("fast clock low too short");
	chk_read_upper_zero: assert property (
		read && !waitrequest |-> readdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	chk_bus_first_wait: assert property (
		(read || write) && !$past(read || write) |-> waitrequest)
		else $error("no wait in first access cycle");
endmodule

// file: testbench/scpm_top_tb.sv
// self-checking bench of the clock and power mode control block
// assumes the checker and core model files are compiled first
module scpm_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import scpm_pkg::*;
	logic clk, reset, read, write, waitrequest, wdt_enable, wdt_timeout;
	logic wdt_clear, cpu_halt, wake_request, sys_clk, fast_clk, slow_clk;
	logic wdt_clk, timebase_clk, cpu_run, power_down_flag, irq;
	logic watchdog_timeout_flag;
	logic [2:0] address;
	logic [31:0] writedata, readdata;
	logic [3:0] byteenable;
	logic [7:0] v;
	scpm_mode_type mode;
	scpm_mode_type exp_mode[4] = '{scpm_sleep, scpm_idle_slow_only,
		scpm_idle_fast_only, scpm_idle_both_clocks};
	int mismatches = 0;
	int n_checks = 0;
	int n, cur, tar, prev;
	time t0;
	// 20 MHz clock
	always #25 clk = ~clk;
	scpm_top dut_u (.clk(clk), .reset(reset), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .cpu_halt(cpu_halt),
		.wake_request(wake_request), .wdt_enable(wdt_enable),
		.wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear),
		.sys_clk(sys_clk), .fast_clk(fast_clk), .slow_clk(slow_clk),
		.wdt_clk(wdt_clk), .timebase_clk(timebase_clk),
		.cpu_run(cpu_run), .mode(mode),
		.power_down_flag(power_down_flag),
		.watchdog_timeout_flag(watchdog_timeout_flag), .irq(irq));
	scpm_core_model core_u (.clk(clk), .cpu_halt(cpu_halt),
		.wake_request(wake_request));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one avalon access; holds until waitrequest is seen low
	task bus(input logic [2:0] a, input logic wr, input logic [7:0] wd,
		output logic [7:0] rd);
		@(posedge clk);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {24'h0, wd};
		byteenable <= 4'hf;
		@(posedge clk);
		while (waitrequest !== 1'b0)
			@(posedge clk);
		rd = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		bus(a, 1'b1, d, v);
	endtask
	task rdchk(input logic [2:0] a, input logic [7:0] exp);
		bus(a, 1'b0, 8'h00, v);
		check({24'h0, v}, {24'h0, exp});
	endtask
	// clk cycles between two rising system clock edges
	task period(output int p);
		@(posedge sys_clk);
		t0 = $time;
		@(posedge sys_clk);
		p = int'(($time - t0) / 50);
	endtask
	task give_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// watchdog against a hung wait
	initial begin
		#3000000;
		mismatches++;
		give_verdict();
	end
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		{address, read, write, writedata, byteenable} = '0;
		{wdt_timeout, wdt_clear} = 2'b00;
		wdt_enable = 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		rdchk(3'h0, 8'h00);
		rdchk(3'h1, 8'h01);
		repeat (330) @(posedge clk);
		rdchk(3'h1, 8'h03);
		wr(3'h1, 8'hff);
		rdchk(3'h1, 8'h03);
		wr(3'h0, 8'h1c);
		rdchk(3'h0, 8'h00);
		wr(3'h6, 8'hff);
		rdchk(3'h6, 8'h00);
		// every halt mode, with the timeout flag set beforehand
		for (int en = 0; en < 4; en++) begin
			wdt_enable <= (en != 0);
			wr(3'h0, 8'(en));
			rdchk(3'h0, 8'(en));
			wr(3'h4, en[0] ? 8'h04 : 8'h00);
			wdt_timeout <= 1'b1;
			@(posedge clk);
			wdt_timeout <= 1'b0;
			core_u.do_halt();
			repeat (4) @(posedge clk);
			check(mode, exp_mode[en]);
			check({power_down_flag, watchdog_timeout_flag}, 2'b10);
			check(irq, en[0]);
			rdchk(3'h5, {1'b0, exp_mode[en], 2'b01});
			wr(3'h3, 8'h0f);
			@(posedge clk);
			check(irq, 1'b0);
			core_u.do_wake();
			repeat (2) @(posedge clk);
			check(cpu_run, 1'b1);
		end
		wdt_clear <= 1'b1;
		@(posedge clk);
		wdt_clear <= 1'b0;
		repeat (2) @(posedge clk);
		check(power_down_flag, 1'b0);
		// the fast source restarted on a wake; let it settle first
		do bus(3'h1, 1'b0, 8'h00, v); while (v[1] !== 1'b1);
		// walk every select code; software waits on switch pending
		prev = 0;
		for (int c = 1; c < 8; c++) begin
			t0 = $time;
			wr(3'h0, {3'(c), 5'h00});
			do bus(3'h5, 1'b0, 8'h00, v); while (v[7] !== 1'b0);
			n = int'(($time - t0) / 50);
			cur = 5 << prev;
			tar = (c == 7) ? 625 : 5 << c;
			check(32'(n <= (11 * cur + tar) / 2 + 8), 32'h1);
			period(n);
			check(n, tar);
			prev = c;
		end
		// slow mode: fast oscillator follows its enable
		wr(3'h1, 8'h00);
		repeat (6) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			check(fast_clk, 1'b0);
		end
		wr(3'h1, 8'h01);
		rdchk(3'h1, 8'h01);
		repeat (330) @(posedge clk);
		rdchk(3'h1, 8'h03);
		// stable, switch done and wake events since the last clear
		rdchk(3'h2, 8'h0b);
		give_verdict();
	end
endmodule
bind scpm_top scpm_top_props chk_u (.clk(clk), .reset(reset),
	.read(read), .write(write), .waitrequest(waitrequest),
	.readdata(readdata), .cpu_halt(cpu_halt),
	.wake_request(wake_request), .wdt_enable(wdt_enable),
	.wdt_timeout(wdt_timeout), .fast_clk(fast_clk),
	.slow_clk(slow_clk), .wdt_clk(wdt_clk),
	.timebase_clk(timebase_clk), .cpu_run(cpu_run), .mode(mode),
	.power_down_flag(power_down_flag),
	.watchdog_timeout_flag(watchdog_timeout_flag));
